// ### logic/gws_top.v
// gpio port bank with wake and sysmgmt event status, led drivers and
// group sysmgmt interrupt; host reaches it over a plain register port
// assumes all inputs synchronous to ref_clk_i, clk32_i sampled as data
//
// Behaviour
// - input read returns pin, polarity applied
// - writing data of input port does nothing
// - output pin drives data, polarity applied
// - output read returns last written data
// - output ports raise no wake or sysmgmt events; misc status logs edges of either-edge ports
// - wake status per wake port, polarity edge
// - sysmgmt status and enable per capable port
// - either-edge ports set status on both edges
// - either-edge mode overrides direction, polarity, driver
// - polarity still shapes either-edge reported value
// - either-edge irq needs enable; status write-one-clear
// - misc register gathers either-edge status bits
// - status records events regardless of enables
// - two led controls: on, off, blink
// - standby blinking needs external slow clock
// - group irq ORs enabled sysmgmt and block events
// - sysmgmt pin polarity, driver from port control
// - group irq reaches pin when enable-two bit7
// - enable-two bit6 routes irq to serial slot2
// - enable-two bit5 feeds device irq status
// - port status latched, ANDed with enable
// - block status mirrors source, infrared clears on read
// - control bit0 dir, bit1 invert, bit7 driver
// - pin status and pin enable drive wake
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`include "gws_map.vh"
module gws_top #(
  parameter [7:0]  WAKE_CAP    = 8'hFF,
  parameter [7:0]  SMI_CAP     = 8'h3C,
  parameter [7:0]  EE_CAP      = 8'h0C,
  parameter [2:0]  SMI_PORT    = 3'h0,
  parameter [2:0]  IR_BIT      = 3'h6,
  parameter [31:0] SLOW_DIV    = `GWS_SLOW_DIV,
  parameter [15:0] BLINK_TICKS = `GWS_BLINK_TICKS
) (
  // clock and reset
  input  wire       ref_clk_i,
  input  wire       rst_n_i,
  // register port
  input  wire [7:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       wr_i,
  input  wire       rd_i,
  output reg  [7:0] rdata_o,
  // general purpose pins
  input  wire [7:0] gpio_i,
  output wire [7:0] gpio_o,
  output wire [7:0] gpio_oe_n_o,
  // functional block event levels
  input  wire [7:0] blk_evt_i,
  // standby power and slow clock
  input  wire       standby_i,
  input  wire       clk32_i,
  // interrupt and wake pins
  output reg        sysmgmt_irq_out_n_o,
  output reg        sysmgmt_irq_oe_n_o,
  output reg        serirq_slot2_o,
  output reg        wake_event_out_n_o,
  output reg        wake_event_oe_n_o,
  // led drivers, active low
  output reg  [1:0] led_n_o
);

  reg  [7:0]  ctrl_q [0:7];
  reg  [7:0]  data_q;
  reg  [7:0]  wsts_q;
  reg  [7:0]  wen_q;
  reg  [7:0]  ssts_q;
  reg  [7:0]  sen_q;
  reg  [7:0]  msts_q;
  reg  [7:0]  eesel_q;
  reg  [7:0]  sen1_q;
  reg  [7:0]  sen2_q;
  reg  [1:0]  dev_q;
  reg  [7:0]  pinen_q;
  reg  [7:0]  led_one_control_q;
  reg  [7:0]  led_two_control_q;
  reg         ir_q;
  reg  [7:0]  rdata_d;

  wire [7:0]  val;
  wire [7:0]  evt;
  wire [7:0]  any;
  wire [7:0]  sts2;
  wire        wr_wsts;
  wire        wr_ssts;
  wire        wr_msts;
  wire        rd_sts2;
  wire        group;
  wire        smi_act;
  wire        smi_lvl;
  wire        pin_st;

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_port
      gws_port #(
        .EE_CAP   (EE_CAP[g])
      ) u_port (
        .clk_i    (ref_clk_i),
        .rst_n_i  (rst_n_i),
        .dir_in_i (ctrl_q[g][`GWS_CTRL_DIR]),
        .pol_i    (ctrl_q[g][`GWS_CTRL_POL]),
        .od_i     (ctrl_q[g][`GWS_CTRL_OD]),
        .ee_sel_i (eesel_q[g]),
        .data_i   (data_q[g]),
        .pin_i    (gpio_i[g]),
        .pin_o    (gpio_o[g]),
        .oe_n_o   (gpio_oe_n_o[g]),
        .val_o    (val[g]),
        .evt_o    (evt[g]),
        .any_o    (any[g])
      );
    end
  endgenerate

  assign wr_wsts = wr_i && (addr_i == `GWS_OFF_WSTS);
  assign wr_ssts = wr_i && (addr_i == `GWS_OFF_SSTS);
  assign wr_msts = wr_i && (addr_i == `GWS_OFF_MSTS);
  assign rd_sts2 = rd_i && (addr_i == `GWS_OFF_SSTS2);

  // block status mirrors live levels; only infrared is latched
  assign sts2 = (blk_evt_i & ~(8'h01 << IR_BIT)) | ({7'h00, ir_q} << IR_BIT);

  assign group = (|(ssts_q & sen_q)) | (|(sts2 & sen1_q));
  assign smi_act = group & sen2_q[`GWS_SEN2_PIN];
  // polarity bit set means active high
  assign smi_lvl = ctrl_q[SMI_PORT][`GWS_CTRL_POL] ? smi_act : ~smi_act;
  assign pin_st  = (|(wsts_q & wen_q)) | (dev_q[`GWS_DEV_STS] & dev_q[`GWS_DEV_EN]);

  // control and data registers
  integer i;
  // separate index so the read mux does not share a driver with the bank
  integer j;
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (i = 0; i < 8; i = i + 1)
        ctrl_q[i] <= `GWS_CTRL_RST;
      data_q  <= `GWS_BYTE_RST;
      wen_q   <= `GWS_BYTE_RST;
      sen_q   <= `GWS_BYTE_RST;
      eesel_q <= `GWS_BYTE_RST;
      sen1_q  <= `GWS_BYTE_RST;
      sen2_q  <= `GWS_BYTE_RST;
      pinen_q <= `GWS_BYTE_RST;
      led_one_control_q  <= `GWS_BYTE_RST;
      led_two_control_q  <= `GWS_BYTE_RST;
    end
    else if (wr_i)
    begin
      if ((addr_i & 8'hF8) == `GWS_OFF_CTRL)
        ctrl_q[addr_i[2:0]] <= wdata_i;
      for (i = 0; i < 8; i = i + 1)
        if (addr_i == `GWS_OFF_DATA && !ctrl_q[i][`GWS_CTRL_DIR])
          data_q[i] <= wdata_i[i];
      case (addr_i)
        `GWS_OFF_WEN:   wen_q   <= wdata_i & WAKE_CAP;
        `GWS_OFF_SEN:   sen_q   <= wdata_i & SMI_CAP;
        `GWS_OFF_EESEL: eesel_q <= wdata_i & EE_CAP;
        `GWS_OFF_SEN1:  sen1_q  <= wdata_i;
        `GWS_OFF_SEN2:  sen2_q  <= wdata_i;
        `GWS_OFF_PINEN: pinen_q <= wdata_i;
        `GWS_OFF_LED_ONE_CONTROL:  led_one_control_q  <= wdata_i;
        `GWS_OFF_LED_TWO_CONTROL:  led_two_control_q  <= wdata_i;
        default:        ;
      endcase
    end
  end

  // sticky status: new event ORed after the clear so it survives
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wsts_q <= `GWS_BYTE_RST;
      ssts_q <= `GWS_BYTE_RST;
      msts_q <= `GWS_BYTE_RST;
      dev_q  <= 2'h0;
      ir_q   <= 1'b0;
    end
    else
    begin
      wsts_q <= (wsts_q & ~({8{wr_wsts}} & wdata_i)) | (evt & WAKE_CAP);
      ssts_q <= (ssts_q & ~({8{wr_ssts}} & wdata_i)) | (evt & SMI_CAP);
      msts_q <= (msts_q & ~({8{wr_msts}} & wdata_i)) | any;
      dev_q[`GWS_DEV_STS] <= (dev_q[`GWS_DEV_STS] &
                              ~(wr_i && addr_i == `GWS_OFF_DEVST && wdata_i[`GWS_DEV_STS]))
                             | (group & sen2_q[`GWS_SEN2_WAKE]);
      if (wr_i && addr_i == `GWS_OFF_DEVST)
        dev_q[`GWS_DEV_EN] <= wdata_i[`GWS_DEV_EN];
      // read clears infrared, the infrared level high in the same cycle keeps it
      ir_q <= (ir_q & ~rd_sts2) | blk_evt_i[IR_BIT];
    end
  end

  // read mux, data one cycle after the strobe
  always @*
  begin
    rdata_d = 8'h00;
    if ((addr_i & 8'hF8) == `GWS_OFF_CTRL)
      rdata_d = ctrl_q[addr_i[2:0]];
    else
      case (addr_i)
        `GWS_OFF_DATA:
          for (j = 0; j < 8; j = j + 1)
            rdata_d[j] = ctrl_q[j][`GWS_CTRL_DIR] | (EE_CAP[j] & eesel_q[j])
                         ? val[j] : data_q[j];
        `GWS_OFF_WSTS:  rdata_d = wsts_q;
        `GWS_OFF_WEN:   rdata_d = wen_q;
        `GWS_OFF_SSTS:  rdata_d = ssts_q;
        `GWS_OFF_SEN:   rdata_d = sen_q;
        `GWS_OFF_MSTS:  rdata_d = msts_q;
        `GWS_OFF_EESEL: rdata_d = eesel_q;
        `GWS_OFF_SSTS2: rdata_d = sts2;
        `GWS_OFF_SEN1:  rdata_d = sen1_q;
        `GWS_OFF_SEN2:  rdata_d = sen2_q;
        `GWS_OFF_DEVST: rdata_d = {6'h00, dev_q};
        `GWS_OFF_PINST: rdata_d = {7'h00, pin_st};
        `GWS_OFF_PINEN: rdata_d = pinen_q;
        `GWS_OFF_LED_ONE_CONTROL:  rdata_d = led_one_control_q;
        `GWS_OFF_LED_TWO_CONTROL:  rdata_d = led_two_control_q;
        default:        rdata_d = 8'h00;
      endcase
  end

  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_o <= 8'h00;
    else if (rd_i)
      rdata_o <= rdata_d;
    else
      rdata_o <= 8'h00;
  end

  // interrupt and wake pins; open-drain only ever pulls low
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sysmgmt_irq_out_n_o <= 1'b1;
      sysmgmt_irq_oe_n_o  <= 1'b1;
      serirq_slot2_o      <= 1'b0;
      wake_event_out_n_o  <= 1'b1;
      wake_event_oe_n_o   <= 1'b1;
    end
    else
    begin
      sysmgmt_irq_out_n_o <= smi_lvl;
      sysmgmt_irq_oe_n_o  <= ctrl_q[SMI_PORT][`GWS_CTRL_OD] & smi_lvl;
      serirq_slot2_o      <= group & sen2_q[`GWS_SEN2_SER];
      wake_event_out_n_o  <= ~(pin_st & pinen_q[0]);
      wake_event_oe_n_o   <= ~(pin_st & pinen_q[0]);
    end
  end

  // blink timebase: slow ticks from a divider, or the external
  // slow clock under standby, so with it absent blinking freezes
  reg  [31:0] div_q;
  reg         c32_q;
  reg  [15:0] blink_cnt_q;
  reg         phase_q;
  wire        div_tick;
  wire        tick;

  assign div_tick = (div_q == SLOW_DIV - 32'h0000_0001);
  assign tick     = standby_i ? (clk32_i & ~c32_q) : div_tick;

  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      div_q       <= 32'h0000_0000;
      c32_q       <= 1'b0;
      blink_cnt_q <= 16'h0000;
      phase_q     <= 1'b0;
      led_n_o     <= 2'h3;
    end
    else
    begin
      div_q <= div_tick ? 32'h0000_0000 : div_q + 32'h0000_0001;
      c32_q <= clk32_i;
      if (tick)
      begin
        if (blink_cnt_q == BLINK_TICKS - 16'h0001)
        begin
          blink_cnt_q <= 16'h0000;
          phase_q     <= ~phase_q;
        end
        else
          blink_cnt_q <= blink_cnt_q + 16'h0001;
      end
      led_n_o[0] <= ~(led_one_control_q[`GWS_LED_BLINK] ? phase_q : led_one_control_q[`GWS_LED_ON]);
      led_n_o[1] <= ~(led_two_control_q[`GWS_LED_BLINK] ? phase_q : led_two_control_q[`GWS_LED_ON]);
    end
  end

endmodule // gws_top

// ### logic/gws_map.vh
// register offsets, field positions, reset values and timing for the gpio
// wake/sysmgmt block; definitions only, included by the top block file
`ifndef GWS_MAP_VH
`define GWS_MAP_VH

// offsets (control register of port i sits at GWS_OFF_CTRL + i)
`define GWS_OFF_CTRL   8'h00
`define GWS_OFF_DATA   8'h10
`define GWS_OFF_WSTS   8'h20
`define GWS_OFF_WEN    8'h21
`define GWS_OFF_SSTS   8'h22
`define GWS_OFF_SEN    8'h23
`define GWS_OFF_MSTS   8'h24
`define GWS_OFF_EESEL  8'h25
`define GWS_OFF_SSTS2  8'h26
`define GWS_OFF_SEN1   8'h27
`define GWS_OFF_SEN2   8'h28
`define GWS_OFF_DEVST  8'h29
`define GWS_OFF_PINST  8'h2A
`define GWS_OFF_PINEN  8'h2B
`define GWS_OFF_LED_ONE_CONTROL   8'h5D
`define GWS_OFF_LED_TWO_CONTROL   8'h5E

// port control fields
`define GWS_CTRL_DIR   0
`define GWS_CTRL_POL   1
`define GWS_CTRL_OD    7
// sysmgmt enable two routing fields
`define GWS_SEN2_PIN   7
`define GWS_SEN2_SER   6
`define GWS_SEN2_WAKE  5
// device irq status register fields
`define GWS_DEV_STS    0
`define GWS_DEV_EN     1
// led control fields
`define GWS_LED_ON     0
`define GWS_LED_BLINK  1

// reset values: input, non-inverted, open-drain
`define GWS_CTRL_RST   8'h81
`define GWS_BYTE_RST   8'h00

// timing
`define GWS_REF_HZ      32'h0BEB_C200
`define GWS_SLOW_HZ     32'h0000_8000
`define GWS_SLOW_DIV    (`GWS_REF_HZ / `GWS_SLOW_HZ)
`define GWS_BLINK_TICKS 16'h4000

`endif

// ### logic/gws_port.v
// one general purpose port: pin drive, polarity, edge events
// assumes pin_i is synchronous to clk_i
`timescale 1ns/1ps
module gws_port #(
  parameter EE_CAP = 1'b0
) (
  // clock and reset
  input  wire clk_i,
  input  wire rst_n_i,
  // configuration
  input  wire dir_in_i,
  input  wire pol_i,
  input  wire od_i,
  input  wire ee_sel_i,
  input  wire data_i,
  // pin
  input  wire pin_i,
  output reg  pin_o,
  output reg  oe_n_o,
  // events and read value
  output wire val_o,
  output wire evt_o,
  output wire any_o
);

  reg  prev_q;
  wire ee_act;
  wire is_in;
  wire any;
  wire rise_v;
  wire drv;

  // either-edge mode forces input, ignoring dir/od; pol still inverts val_o
  assign ee_act = EE_CAP & ee_sel_i;
  assign is_in  = dir_in_i | ee_act;
  assign any    = pin_i ^ prev_q;
  assign rise_v = (pin_i ^ pol_i) & ~(prev_q ^ pol_i);
  assign val_o  = pin_i ^ pol_i;
  // outputs never raise events
  assign evt_o  = is_in & (ee_act ? any : rise_v);
  // misc status logs edges whether or not the mode is selected
  assign any_o  = EE_CAP & any;
  assign drv    = data_i ^ pol_i;

  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      prev_q <= 1'b0;
      pin_o  <= 1'b0;
      oe_n_o <= 1'b1;
    end
    else
    begin
      prev_q <= pin_i;
      pin_o  <= is_in ? 1'b0 : drv;
      oe_n_o <= is_in | (od_i & drv);
    end
  end

endmodule // gws_port

// ### verif/gws_pin_model.sv
// board model at the pins of gws_top
// assumes the bench drives the pin levels of ports that are released
`timescale 1ns/1ps
module gws_pin_model (
  // design side
  input  logic [7:0] gpio_d_i,
  input  logic [7:0] gpio_oe_n_i,
  input  logic       smi_d_i,
  input  logic       smi_oe_n_i,
  input  logic       wake_d_i,
  input  logic       wake_oe_n_i,
  // board side
  input  logic [7:0] ext_val_i,
  output logic [7:0] gpio_o,
  output logic       smi_wire_o,
  output logic       wake_wire_o
);
  // a driving port wins; released ports see the board level
  assign gpio_o      = (~gpio_oe_n_i & gpio_d_i) | (gpio_oe_n_i & ext_val_i);
  // pull-ups hold released interrupt lines high
  assign smi_wire_o  = smi_oe_n_i ? 1'b1 : smi_d_i;
  assign wake_wire_o = wake_oe_n_i ? 1'b1 : wake_d_i;
endmodule // gws_pin_model

// ### verif/gws_top_assertions.sv
// checker for gws_top: read timing, pin release, led steadiness
// assumes one clock domain, bound to every gws_top
`timescale 1ns/1ps
module gws_checker (
  // clock and reset
  input logic       ref_clk_i,
  input logic       rst_n_i,
  // register port
  input logic [7:0] addr_i,
  input logic [7:0] wdata_i,
  input logic       wr_i,
  input logic       rd_i,
  input logic [7:0] rdata_o,
  // pins
  input logic [7:0] gpio_o,
  input logic [7:0] gpio_oe_n_o,
  input logic       standby_i,
  input logic       clk32_i,
  input logic       wake_event_out_n_o,
  input logic       wake_event_oe_n_o,
  input logic [1:0] led_n_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [7:0] led_one_control_q;
  logic [7:0] led_two_control_q;
  logic [3:0] calm_q;
  logic       c32_q;
  // calm waits out the slow-clock sampling pipeline
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      led_one_control_q <= 8'h00;
      led_two_control_q <= 8'h00;
      calm_q <= 4'h0;
      c32_q  <= 1'b0;
    end
    else
    begin
      c32_q <= clk32_i;
      if (wr_i && addr_i == 8'h5D)
        led_one_control_q <= wdata_i;
      if (wr_i && addr_i == 8'h5E)
        led_two_control_q <= wdata_i;
      if (!standby_i || wr_i || clk32_i != c32_q)
        calm_q <= 4'h0;
      else if (calm_q != 4'hF)
        calm_q <= calm_q + 4'h1;
    end
  sequence rd_at(logic [7:0] a);
    rd_i && addr_i == a;
  endsequence
  sequence ctrl_in_wr;
    wr_i && addr_i[7:3] == 5'h00 && wdata_i[0];
  endsequence
  property read_back(logic [7:0] a, logic [7:0] v);
    rd_at(a) |=> rdata_o == v;
  endproperty
  rdata_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data seen without a read");
  led_one_control_back_a: assert property (read_back(8'h5D, led_one_control_q))
    else $error("led one control read back wrong");
  led_two_control_back_a: assert property (read_back(8'h5E, led_two_control_q))
    else $error("led two control read back wrong");
  pin_status_a: assert property (rd_at(8'h2A) |=> rdata_o[7:1] == 7'h00)
    else $error("wake pin status has extra bits");
  gpio_release_a: assert property ((gpio_o & gpio_oe_n_o) == 8'h00)
    else $error("released port shows drive value");
  wake_oe_a: assert property (wake_event_oe_n_o == wake_event_out_n_o)
    else $error("wake enable differs from wake level");
  led_standby_a: assert property (calm_q >= 4'h6 |-> $stable(led_n_o))
    else $error("led changed in standby without slow clock");
  ctrl_input_a: assert property (ctrl_in_wr |-> ##2 gpio_oe_n_o[$past(addr_i, 2)])
    else $error("input port still driving");
endmodule // gws_checker

bind gws_top gws_checker i_chk (.ref_clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
  .rdata_o, .gpio_o, .gpio_oe_n_o, .standby_i, .clk32_i, .wake_event_out_n_o,
  .wake_event_oe_n_o, .led_n_o);

// ### verif/gws_top_tb.sv
// self-checking bench for gws_top: bus, pins, events, leds
// assumes gws_top, gws_pin_model and the bound checker are compiled
`timescale 1ns/1ps
module gws_top_tb;
  logic       ref_clk_i = 1'b0;
  logic       rst_n_i   = 1'b0;
  logic [7:0] addr_i    = 8'h00;
  logic [7:0] wdata_i   = 8'h00;
  logic       wr_i      = 1'b0;
  logic       rd_i      = 1'b0;
  logic       standby_i = 1'b0;
  logic       clk32_i   = 1'b0;
  logic [7:0] ext_val   = 8'h00;
  logic [7:0] blk_evt   = 8'h00;
  logic [7:0] rdata_o, gpio_i, gpio_o, gpio_oe_n_o;
  logic       smi_n, smi_oe_n, serirq, wake_n, wake_oe_n, smi_w, wake_w;
  logic [1:0] led_n_o;
  int         n_mismatch = 0;
  int         n_compared = 0;

  always #2.5 ref_clk_i = ~ref_clk_i;

  // short counts keep blink periods to tens of cycles
  gws_top #(.SLOW_DIV(32'h0000_0004), .BLINK_TICKS(16'h0004)) i_dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .gpio_i(gpio_i), .gpio_o(gpio_o),
    .gpio_oe_n_o(gpio_oe_n_o), .blk_evt_i(blk_evt), .standby_i(standby_i),
    .clk32_i(clk32_i), .sysmgmt_irq_out_n_o(smi_n), .sysmgmt_irq_oe_n_o(smi_oe_n),
    .serirq_slot2_o(serirq), .wake_event_out_n_o(wake_n), .wake_event_oe_n_o(wake_oe_n),
    .led_n_o(led_n_o));
  gws_pin_model i_pins (.gpio_d_i(gpio_o), .gpio_oe_n_i(gpio_oe_n_o), .smi_d_i(smi_n),
    .smi_oe_n_i(smi_oe_n), .wake_d_i(wake_n), .wake_oe_n_i(wake_oe_n),
    .ext_val_i(ext_val), .gpio_o(gpio_i), .smi_wire_o(smi_w), .wake_wire_o(wake_w));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    wr_i    <= 1'b0;
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] m,
                       input logic [7:0] exp);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    rd_i   <= 1'b0;
    #1;
    chk(what, exp, rdata_o & m);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic pin(input int k, input logic v);
    @(posedge ref_clk_i);
    ext_val[k] <= v;
  endtask
  task automatic flips(input int n, output logic [7:0] f);
    logic [1:0] was;
    f = 8'h00;
    was = led_n_o;
    repeat (n)
    begin
      tick(1);
      if (led_n_o !== was)
        f = f + 8'h01;
      was = led_n_o;
    end
  endtask

  task automatic t_reset;
    rdchk("ctrl reset", 8'h00, 8'hFF, 8'h81);
    rdchk("led reset", 8'h5D, 8'hFF, 8'h00);
  endtask
  task automatic t_input;
    pin(1, 1'b1);
    tick(3);
    rdchk("input read", 8'h10, 8'h02, 8'h02);
    wr(8'h01, 8'h83);
    tick(2);
    rdchk("inverted read", 8'h10, 8'h02, 8'h00);
    wr(8'h10, 8'hFF);
    tick(2);
    chk("input not driven", 8'h02, gpio_oe_n_o & 8'h02);
    rdchk("input write ignored", 8'h10, 8'h02, 8'h00);
  endtask
  task automatic t_output;
    wr(8'h04, 8'h00);
    wr(8'h10, 8'h10);
    wr(8'h20, 8'hFF);
    tick(2);
    chk("pin drives data", 8'h10, {3'h0, gpio_o[4], gpio_oe_n_o[4], 3'h0});
    wr(8'h04, 8'h02);
    tick(2);
    chk("pin drives inverse", 8'h00, gpio_o & 8'h10);
    rdchk("output read", 8'h10, 8'h10, 8'h10);
    rdchk("output no event", 8'h20, 8'h10, 8'h00);
  endtask
  task automatic t_events;
    wr(8'h20, 8'hFF);
    wr(8'h22, 8'hFF);
    pin(5, 1'b1);
    tick(3);
    rdchk("wake status rise", 8'h20, 8'h20, 8'h20);
    rdchk("sysmgmt status rise", 8'h22, 8'h20, 8'h20);
    wr(8'h20, 8'h20);
    pin(5, 1'b0);
    tick(3);
    rdchk("no status on fall", 8'h20, 8'h20, 8'h00);
  endtask
  task automatic t_either;
    wr(8'h25, 8'h04);
    wr(8'h20, 8'hFF);
    wr(8'h22, 8'hFF);
    wr(8'h24, 8'hFF);
    wr(8'h23, 8'h04);
    wr(8'h21, 8'h04);
    wr(8'h2B, 8'h01);
    wr(8'h28, 8'hC0);
    pin(2, 1'b1);
    tick(4);
    rdchk("misc status", 8'h24, 8'h04, 8'h04);
    rdchk("wake pin status", 8'h2A, 8'hFF, 8'h01);
    chk("lines asserted", 8'h01, {5'h00, smi_w, wake_w, serirq});
    wr(8'h20, 8'h04);
    wr(8'h22, 8'h04);
    tick(3);
    chk("lines released", 8'h06, {5'h00, smi_w, wake_w, serirq});
    pin(2, 1'b0);
    tick(3);
    rdchk("fall status", 8'h22, 8'h04, 8'h04);
    wr(8'h28, 8'h20);
    wr(8'h29, 8'h02);
    tick(3);
    rdchk("device irq status", 8'h29, 8'h01, 8'h01);
    wr(8'h22, 8'hFF);
  endtask
  // block events: live mirror, infrared latched until the status is read
  task automatic t_block;
    wr(8'h28, 8'h80);
    wr(8'h27, 8'h01);
    @(posedge ref_clk_i);
    blk_evt <= 8'h41;
    tick(3);
    chk("block irq line", 8'h00, {7'h00, smi_w});
    rdchk("block status mirror", 8'h26, 8'hFF, 8'h41);
    @(posedge ref_clk_i);
    blk_evt <= 8'h00;
    tick(3);
    chk("block irq released", 8'h01, {7'h00, smi_w});
    wr(8'h26, 8'hFF);
    rdchk("infrared held", 8'h26, 8'hFF, 8'h40);
    rdchk("infrared read clear", 8'h26, 8'hFF, 8'h00);
  endtask
  task automatic t_led;
    logic [7:0] f;
    wr(8'h5D, 8'h01);
    wr(8'h5E, 8'h02);
    tick(3);
    chk("led one lit", 8'h00, {7'h00, led_n_o[0]});
    flips(80, f);
    chk("led two blinks", 8'h01, {7'h00, f != 8'h00});
    standby_i <= 1'b1;
    tick(10);
    flips(40, f);
    chk("standby no blink", 8'h00, f);
    fork
      flips(60, f);
      repeat (20)
      begin
        tick(3);
        clk32_i <= ~clk32_i;
      end
    join
    chk("standby blink", 8'h01, {7'h00, f != 8'h00});
    chk("standby steady on", 8'h00, {7'h00, led_n_o[0]});
    standby_i <= 1'b0;
  endtask

  task automatic conclude;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_input();
    t_output();
    t_events();
    t_either();
    t_block();
    t_led();
    conclude();
  end
  initial
  begin
    #200000;
    n_mismatch++;
    conclude();
  end
endmodule // gws_top_tb
